// ===== core/sensor_cfg_pkg.sv
/*
 * Shared constants for the sensor configuration and bus address block:
 * field positions of the configuration word and the output control word,
 * default cell values, gain table codes and the receiver state codes.
 * Assumes nothing of its surroundings; sensor_config and its checker import it.
 */
package sensor_cfg_pkg;

    // Field positions of the analog/digital configuration word.
    localparam int IIR_LSB = 0;
    localparam int IIR_MSB = 2;
    localparam int AMB_TYPE_BIT = 3;
    localparam int PWM_SEL_LSB = 4;
    localparam int PWM_SEL_MSB = 5;
    localparam int DUAL_IR_BIT = 6;
    localparam int SLOPE_SIGN_BIT = 7;
    localparam int FIR_LSB = 8;
    localparam int FIR_MSB = 10;
    localparam int GAIN_LSB = 11;
    localparam int GAIN_MSB = 13;
    localparam int CAL_LSB = 14;
    localparam int CAL_MSB = 15;

    // Field positions of the output control word.
    localparam int OC_SINGLE_BIT = 0;
    localparam int OC_PWM_EN_BIT = 1;
    localparam int OC_PUSH_PULL_BIT = 2;
    localparam int OC_RELAY_BIT = 3;

    // Reset values held before the cells are loaded after reset, and the general call address.
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] OUT_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ADDR_CELL_DEFAULT = 16'h005a;
    localparam logic [6:0] GENERAL_ADDR = 7'h00;

    // Slave address frame length in bits, address plus direction.
    localparam logic [3:0] ADDR_FRAME_BITS = 4'h8;

    // Pulse output data items.
    typedef enum logic [1:0] {
        ITEM_AMBIENT = 2'b00,
        ITEM_IR_FIRST = 2'b01,
        ITEM_IR_SECOND = 2'b10,
        ITEM_UNDEFINED = 2'b11
    } data_item_t;

    // Pulse data selection codes.
    localparam logic [1:0] SEL_AMB_IR1 = 2'b00;
    localparam logic [1:0] SEL_AMB_IR2 = 2'b01;
    localparam logic [1:0] SEL_IR2_UNDEF = 2'b10;
    localparam logic [1:0] SEL_IR1_IR2 = 2'b11;

    // Amplifier gain times ten, indexed by the gain code.
    localparam logic [10:0] GAIN_X10_0 = 11'h00a;
    localparam logic [10:0] GAIN_X10_1 = 11'h01e;
    localparam logic [10:0] GAIN_X10_2 = 11'h03c;
    localparam logic [10:0] GAIN_X10_3 = 11'h07d;
    localparam logic [10:0] GAIN_X10_4 = 11'h0fa;
    localparam logic [10:0] GAIN_X10_5 = 11'h1f4;
    localparam logic [10:0] GAIN_X10_MAX = 11'h3e8;

    // Address receiver states.
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_ADDR = 2'b01,
        RX_WAIT = 2'b10
    } rx_state_t;

endpackage : sensor_cfg_pkg

// ===== core/pin_ctrl_if.sv
/*
 * Carrier between the main block and the shared pin driver.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pin_ctrl_if;
    logic pwm_mode;
    logic push_pull;
    logic pwm_level;
    logic sda_low;
    logic pin_out;
    logic pin_oe;

    modport ctl (output pwm_mode, output push_pull, output pwm_level, output sda_low,
                 input pin_out, input pin_oe);
    modport drv (input pwm_mode, input push_pull, input pwm_level, input sda_low,
                 output pin_out, output pin_oe);
endinterface : pin_ctrl_if

// ===== core/pin_sync3.sv
/*
 * Three-stage synchroniser with agreement filter and edge pulses.
 * Assumes asynchronous inputs; the first stage is read only by the second.
 */
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // A change is accepted once the second and third stages agree.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_reg[i] <= 1'b1;
                    s2_reg[i] <= 1'b1;
                    s3_reg[i] <= 1'b1;
                    q[i] <= 1'b1;
                    rise[i] <= 1'b0;
                    fall[i] <= 1'b0;
                end else if (ce) begin
                    s1_reg[i] <= d[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    rise[i] <= (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !q[i];
                    fall[i] <= (s2_reg[i] == s3_reg[i]) && !s3_reg[i] && q[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        q[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync3

// ===== core/pin_driver.sv
/*
 * Output stage of the shared data / pulse pin.
 * Assumes the controls come from the same clock; the pin wire is resolved outside.
 */
`timescale 1ns/1ps
module pin_driver (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    pin_ctrl_if.drv pc
);
    // Registered so the pin never glitches between mode changes.
    always_ff @(posedge clk) begin
        if (rst) begin
            pc.pin_out <= 1'b0;
            pc.pin_oe <= 1'b0;
        end else if (ce) begin
            if (!pc.pwm_mode) begin
                pc.pin_out <= 1'b0;
                pc.pin_oe <= pc.sda_low;
            end else if (pc.push_pull) begin
                pc.pin_out <= pc.pwm_level;
                pc.pin_oe <= 1'b1;
            end else begin
                pc.pin_out <= 1'b0;
                pc.pin_oe <= !pc.pwm_level;
            end
        end
    end
endmodule : pin_driver

// ===== core/sensor_config.sv
/*
 * Configuration word decoder, slave address matcher and shared pin control
 * of the infrared temperature sensor.
 * Assumes the nonvolatile cells are presented as steady words on the
 * nv_* inputs, the bus engine and pulse generator share clk, and the
 * serial clock and data pins arrive asynchronously.
 */
// How it works
// - Bits 2..0 give the recursive smoothing filter coefficients.
// - Bit 3 picks ambient sensor type, zero is the proportional element.
// - Bits 5..4 choose the two pulse data items; code 10 is discouraged extended.
// - Bit 6 set means two infrared sensors, clear means one.
// - Bits 10..8 give coefficient N of the finite response filter.
// - Bits 13..11 set amplifier gain 1,3,6,12.5,25,50,100,100.
// - Only the low byte of the address cell is compared.
// - Slave address zero is always accepted in bus mode.
// - A shipped device holds the default slave address.
// - The serial clock pin is only an input and clocks bus bits.
// - The shared pin carries pulse output or bus data by mode.
// - The pin driver is push-pull or open-drain, open-drain by default.
// - In bus mode the pin is always open-drain.
// - Push-pull applies only in pulse or thermal relay operation.
// - Output control bit 2 set is push-pull, clear open-drain.
// - Output control bit 1 set enables pulse output, clear enables bus.
// - Changed cells take effect only after the next reset.
`timescale 1ns/1ps
module sensor_config
    import sensor_cfg_pkg::*;
#(
    parameter logic [15:0] ADDR_DEFAULT = ADDR_CELL_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [15:0] nv_config_word,
    input wire logic [15:0] nv_address_cell,
    input wire logic nv_address_valid,
    input wire logic [15:0] nv_output_control,
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    input wire logic pwm_level,
    input wire logic sda_drive_low,
    output logic sda_pin_out,
    output logic sda_pin_oe,
    output logic cells_loaded,
    output logic [2:0] iir_coeff,
    output logic ambient_alt_type,
    output logic [1:0] pwm_data_sel,
    output data_item_t pwm_first_item,
    output data_item_t pwm_second_item,
    output logic pwm_sel_discouraged,
    output logic dual_ir,
    output logic emissivity_slope_sign,
    output logic [2:0] fir_coeff_n,
    output logic [2:0] gain_code,
    output logic [10:0] gain_x10,
    output logic amp_bypass,
    output logic [1:0] factory_cal_bits,
    output logic pwm_mode,
    output logic push_pull,
    output logic thermal_relay,
    output logic single_pwm,
    output logic [6:0] own_address,
    output logic bit_clk_rise,
    output logic bus_data,
    output logic addr_hit,
    output logic addr_general,
    output logic addr_read
);

    // Gain code to gain times ten; the two top codes both give 100.
    function automatic logic [10:0] gain_lookup(input logic [2:0] code);
        case (code)
            3'h0: gain_lookup = GAIN_X10_0;
            3'h1: gain_lookup = GAIN_X10_1;
            3'h2: gain_lookup = GAIN_X10_2;
            3'h3: gain_lookup = GAIN_X10_3;
            3'h4: gain_lookup = GAIN_X10_4;
            3'h5: gain_lookup = GAIN_X10_5;
            default: gain_lookup = GAIN_X10_MAX;
        endcase
    endfunction : gain_lookup

    // Selection code to the first and second pulse data items.
    function automatic data_item_t item_lookup(input logic [1:0] sel, input logic second);
        case (sel)
            SEL_AMB_IR1: item_lookup = second ? ITEM_IR_FIRST : ITEM_AMBIENT;
            SEL_AMB_IR2: item_lookup = second ? ITEM_IR_SECOND : ITEM_AMBIENT;
            SEL_IR1_IR2: item_lookup = second ? ITEM_IR_SECOND : ITEM_IR_FIRST;
            SEL_IR2_UNDEF: item_lookup = second ? ITEM_UNDEFINED : ITEM_IR_SECOND;
            default: item_lookup = ITEM_UNDEFINED;
        endcase
    endfunction : item_lookup

    logic load_pending_reg;
    logic [15:0] config_reg;
    logic [15:0] addr_cell_reg;
    logic [15:0] out_ctrl_reg;

    // The cells are captured one cycle after reset release rather than under
    // reset, so the reset itself only ever loads constants. Nothing reloads
    // them later, which is what makes edits wait for the next reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            load_pending_reg <= 1'b1;
            config_reg <= CONFIG_RESET;
            addr_cell_reg <= ADDR_DEFAULT;
            out_ctrl_reg <= OUT_CTRL_RESET;
        end else if (ce && load_pending_reg) begin
            load_pending_reg <= 1'b0;
            config_reg <= nv_config_word;
            out_ctrl_reg <= nv_output_control;
            if (nv_address_valid) begin
                addr_cell_reg <= nv_address_cell;
            end
        end
    end

    assign cells_loaded = !load_pending_reg;

    // Configuration word fields, all straight from the holding register.
    assign iir_coeff = config_reg[IIR_MSB:IIR_LSB];
    assign ambient_alt_type = config_reg[AMB_TYPE_BIT];
    assign pwm_data_sel = config_reg[PWM_SEL_MSB:PWM_SEL_LSB];
    assign dual_ir = config_reg[DUAL_IR_BIT];
    assign emissivity_slope_sign = config_reg[SLOPE_SIGN_BIT];
    assign fir_coeff_n = config_reg[FIR_MSB:FIR_LSB];
    assign gain_code = config_reg[GAIN_MSB:GAIN_LSB];
    assign factory_cal_bits = config_reg[CAL_MSB:CAL_LSB];

    // Output control fields.
    assign single_pwm = out_ctrl_reg[OC_SINGLE_BIT];
    assign pwm_mode = out_ctrl_reg[OC_PWM_EN_BIT];
    assign push_pull = out_ctrl_reg[OC_PUSH_PULL_BIT];
    assign thermal_relay = out_ctrl_reg[OC_RELAY_BIT];

    // Only the low byte counts; the top bit of that byte would never match a
    // seven-bit address and so disables matching of the own address.
    assign own_address = addr_cell_reg[6:0];

    // Derived decodes are registered so every data output comes from a flop.
    always_ff @(posedge clk) begin
        if (rst) begin
            gain_x10 <= GAIN_X10_0;
            amp_bypass <= 1'b1;
            pwm_first_item <= ITEM_AMBIENT;
            pwm_second_item <= ITEM_IR_FIRST;
            pwm_sel_discouraged <= 1'b0;
        end else if (ce) begin
            gain_x10 <= gain_lookup(gain_code);
            amp_bypass <= (gain_code == 3'h0);
            pwm_first_item <= item_lookup(pwm_data_sel, 1'b0);
            pwm_second_item <= item_lookup(pwm_data_sel, 1'b1);
            pwm_sel_discouraged <= (pwm_data_sel == SEL_IR2_UNDEF) && !single_pwm;
        end
    end

    // Serial clock and data arrive from the bus, outside this clock domain.
    logic [1:0] pin_q;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    pin_sync3 #(
        .W(2)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({scl_pin, sda_pin_in}),
        .q(pin_q),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic scl_s;
    logic sda_s;
    logic start_cond;
    logic stop_cond;

    // The serial clock is only sampled, never driven; its rising edge
    // is the bit clock for the bus.
    assign scl_s = pin_q[1];
    assign sda_s = pin_q[0];
    assign bit_clk_rise = pin_rise[1] && !pwm_mode;
    assign bus_data = sda_s;
    assign start_cond = pin_fall[0] && scl_s && !pwm_mode;
    assign stop_cond = pin_rise[0] && scl_s && !pwm_mode;

    rx_state_t rx_state_reg;
    rx_state_t rx_state_next;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic frame_done;

    assign frame_done = bit_clk_rise && (bit_cnt_reg == ADDR_FRAME_BITS - 4'h1);

    // Address receiver: watches the first byte after each start, including a
    // repeated start, and then waits for the next start or stop.
    always_comb begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            RX_IDLE: begin
                if (start_cond) begin
                    rx_state_next = RX_ADDR;
                end
            end
            RX_ADDR: begin
                if (stop_cond) begin
                    rx_state_next = RX_IDLE;
                end else if (start_cond) begin
                    rx_state_next = RX_ADDR;
                end else if (frame_done) begin
                    rx_state_next = RX_WAIT;
                end
            end
            RX_WAIT: begin
                if (stop_cond) begin
                    rx_state_next = RX_IDLE;
                end else if (start_cond) begin
                    rx_state_next = RX_ADDR;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
        if (pwm_mode) begin
            rx_state_next = RX_IDLE;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_state_reg <= RX_IDLE;
        end else if (ce) begin
            rx_state_reg <= rx_state_next;
        end
    end

    // Bit counter and shift register, most significant bit first.
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (ce) begin
            if (start_cond) begin
                bit_cnt_reg <= 4'h0;
            end else if (rx_state_reg == RX_ADDR && bit_clk_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], sda_s};
            end
        end
    end

    logic [7:0] frame;
    logic hit_own;
    logic hit_zero;

    assign frame = {shift_reg[6:0], sda_s};
    assign hit_own = (addr_cell_reg[7:0] == {1'b0, frame[7:1]});
    assign hit_zero = (frame[7:1] == GENERAL_ADDR);

    // One-cycle match pulse at the end of the address frame. Address zero
    // is answered whatever the cell holds, so an unprogrammed part is
    // still reachable.
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_hit <= 1'b0;
            addr_general <= 1'b0;
            addr_read <= 1'b0;
        end else if (ce) begin
            addr_hit <= 1'b0;
            addr_general <= 1'b0;
            if (rx_state_reg == RX_ADDR && frame_done && !start_cond && !stop_cond) begin
                addr_hit <= hit_own || hit_zero;
                addr_general <= hit_zero;
                addr_read <= frame[0];
            end
        end
    end

    // Shared pin: mode and driver type from the output control word.
    pin_ctrl_if pc ();

    assign pc.pwm_mode = pwm_mode;
    assign pc.push_pull = push_pull;
    assign pc.pwm_level = pwm_level;
    assign pc.sda_low = sda_drive_low && !pwm_mode;

    pin_driver u_pin (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pc(pc.drv)
    );

    assign sda_pin_out = pc.pin_out;
    assign sda_pin_oe = pc.pin_oe;

endmodule : sensor_config

// ===== bench/sensor_config_properties.sv
/* Concurrent checks for the configuration decoder, address matcher and pin control.
   Sees only the ports of sensor_config and is bound to it below. */
`timescale 1ns/1ps
module sensor_config_properties
    import sensor_cfg_pkg::*;
#(
    parameter logic [15:0] ADDR_DEFAULT = ADDR_CELL_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] nv_config_word,
    input wire logic [15:0] nv_address_cell,
    input wire logic nv_address_valid,
    input wire logic [15:0] nv_output_control,
    input wire logic pwm_level,
    input wire logic sda_drive_low,
    input wire logic sda_pin_out,
    input wire logic sda_pin_oe,
    input wire logic cells_loaded,
    input wire logic [2:0] iir_coeff,
    input wire logic ambient_alt_type,
    input wire logic [1:0] pwm_data_sel,
    input wire data_item_t pwm_first_item,
    input wire data_item_t pwm_second_item,
    input wire logic dual_ir,
    input wire logic [2:0] fir_coeff_n,
    input wire logic [2:0] gain_code,
    input wire logic pwm_mode,
    input wire logic push_pull,
    input wire logic [6:0] own_address,
    input wire logic bit_clk_rise,
    input wire logic addr_hit,
    input wire logic addr_general
);
    // Everything here lives in the one clock domain and is quiet during reset.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Item pairs per selection code, first item in the upper half.
    function automatic logic [3:0] items_of(input logic [1:0] sel);
        case (sel)
            2'b00: return 4'h1;
            2'b01: return 4'h2;
            2'b11: return 4'h6;
            default: return 4'hb;
        endcase
    endfunction : items_of

    a_filter_amb_load: assert property ($rose(cells_loaded) |->
        iir_coeff == nv_config_word[2:0] && ambient_alt_type == nv_config_word[3])
        else $error("filter or ambient field wrong after load");
    a_sel_count_load: assert property ($rose(cells_loaded) |->
        pwm_data_sel == nv_config_word[5:4] && dual_ir == nv_config_word[6])
        else $error("data select or sensor count wrong after load");
    a_fir_gain_load: assert property ($rose(cells_loaded) |->
        fir_coeff_n == nv_config_word[10:8] && gain_code == nv_config_word[13:11])
        else $error("fir or gain field wrong after load");
    a_item_pair_map: assert property (cells_loaded && $past(cells_loaded) |->
        {pwm_first_item, pwm_second_item} == items_of(pwm_data_sel))
        else $error("pulse data items do not match the selection");
    a_fields_hold_run: assert property (cells_loaded && $past(cells_loaded) |->
        $stable({iir_coeff, gain_code, fir_coeff_n, pwm_data_sel, own_address, pwm_mode}))
        else $error("decoded setting changed without reset");
    a_own_addr_load: assert property ($rose(cells_loaded) |-> own_address ==
        (nv_address_valid ? nv_address_cell[6:0] : ADDR_DEFAULT[6:0]))
        else $error("own address wrong after load");
    a_mode_bits_load: assert property ($rose(cells_loaded) |->
        pwm_mode == nv_output_control[1] && push_pull == nv_output_control[2])
        else $error("mode or driver bit wrong after load");
    a_bus_open_drain: assert property (cells_loaded && !pwm_mode |=>
        !sda_pin_out && sda_pin_oe == $past(sda_drive_low))
        else $error("bus mode pin not open drain");
    a_pulse_pin_drive: assert property (cells_loaded && pwm_mode |=>
        (push_pull ? sda_pin_oe && sda_pin_out == $past(pwm_level)
                   : !sda_pin_out && sda_pin_oe == !$past(pwm_level)))
        else $error("pulse mode pin drive wrong");
    a_hit_after_bit: assert property (addr_hit |-> $past(bit_clk_rise))
        else $error("address hit without a bit clock edge before it");
    a_hit_one_cycle: assert property (addr_hit |=> !addr_hit)
        else $error("address hit longer than one cycle");
    a_general_is_hit: assert property (addr_general |-> addr_hit)
        else $error("zero address seen but not accepted");
    a_no_rx_pulse: assert property (cells_loaded && pwm_mode |-> !addr_hit)
        else $error("address accepted in pulse mode");

    c_hit: cover property (addr_hit);
    c_general: cover property (addr_general);
    c_push_pull: cover property (cells_loaded && pwm_mode && push_pull);
endmodule : sensor_config_properties

bind sensor_config sensor_config_properties #(.ADDR_DEFAULT(ADDR_DEFAULT)) i_props (
    .clk(clk), .rst(rst), .nv_config_word(nv_config_word),
    .nv_address_cell(nv_address_cell), .nv_address_valid(nv_address_valid),
    .nv_output_control(nv_output_control), .pwm_level(pwm_level),
    .sda_drive_low(sda_drive_low), .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe),
    .cells_loaded(cells_loaded), .iir_coeff(iir_coeff), .ambient_alt_type(ambient_alt_type),
    .pwm_data_sel(pwm_data_sel), .pwm_first_item(pwm_first_item),
    .pwm_second_item(pwm_second_item), .dual_ir(dual_ir), .fir_coeff_n(fir_coeff_n),
    .gain_code(gain_code), .pwm_mode(pwm_mode), .push_pull(push_pull),
    .own_address(own_address), .bit_clk_rise(bit_clk_rise), .addr_hit(addr_hit),
    .addr_general(addr_general));

// ===== bench/smbus_host_model.sv
/* Bit-banged two-wire bus host sending one address frame at a time.
   Assumes an open-drain data line with pull-up resolved by the bench. */
`timescale 1ns/1ps
module smbus_host_model (
    output logic scl,
    output logic sda_low
);
    // The host owns the serial clock; it rests high between frames.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // START, eight bits MSB first, an acknowledge slot, then STOP.
    task automatic send_frame(input logic [7:0] frame);
        #13 sda_low = 1'b1;
        #400 scl = 1'b0;
        for (int b = 7; b >= 0; b--) begin
            #100 sda_low = !frame[b];
            #300 scl = 1'b1;
            #400 scl = 1'b0;
        end
        #100 sda_low = 1'b0;
        #300 scl = 1'b1;
        #400 scl = 1'b0;
        #100 sda_low = 1'b1;
        #300 scl = 1'b1;
        #400 sda_low = 1'b0;
    endtask : send_frame

    // A rewrite keeps the slope sign, gain and calibration bits of the old word.
    function automatic logic [15:0] keep_cal(input logic [15:0] old_w, input logic [15:0] new_w);
        return {old_w[15:11], new_w[10:8], old_w[7], new_w[6:0]};
    endfunction : keep_cal
endmodule : smbus_host_model

// ===== bench/testbench.sv
/* Self-checking bench for sensor_config: loads random cells, checks decoding,
   pin driving and address matching. Assumes the host model and checker files. */
`timescale 1ns/1ps
module testbench;
    logic clk, rst, ce, addr_valid, pwm_level, sda_drive_low, scl, host_low, byp, disc, rel, sgl;
    logic [15:0] cfg, acell, octl, s, fields;
    logic sda_pin_out, sda_pin_oe, cells_loaded, pwm_mode, addr_hit, addr_general, addr_read;
    logic [10:0] gain_x10;
    logic [6:0] own_address;
    wire sda_wire;
    int mismatches = 0, checks_done = 0, hits = 0, gens = 0;

    // Pull-up on the shared pin; any driver pulling low wins.
    assign sda_wire = (host_low || (sda_pin_oe && !sda_pin_out)) ? 1'b0 : 1'b1;

    sensor_config i_dut (.clk(clk), .rst(rst), .ce(ce), .nv_config_word(cfg),
        .nv_address_cell(acell), .nv_address_valid(addr_valid), .nv_output_control(octl),
        .scl_pin(scl), .sda_pin_in(sda_wire), .pwm_level(pwm_level),
        .sda_drive_low(sda_drive_low), .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe),
        .cells_loaded(cells_loaded), .iir_coeff(fields[2:0]), .ambient_alt_type(fields[3]),
        .pwm_data_sel(fields[5:4]), .pwm_first_item(), .pwm_second_item(),
        .pwm_sel_discouraged(disc), .dual_ir(fields[6]), .emissivity_slope_sign(fields[7]),
        .fir_coeff_n(fields[10:8]), .gain_code(fields[13:11]), .gain_x10(gain_x10),
        .amp_bypass(byp), .factory_cal_bits(fields[15:14]), .pwm_mode(pwm_mode),
        .push_pull(), .thermal_relay(rel), .single_pwm(sgl), .own_address(own_address),
        .bit_clk_rise(), .bus_data(), .addr_hit(addr_hit), .addr_general(addr_general),
        .addr_read(addr_read));

    smbus_host_model i_host (.scl(scl), .sda_low(host_low));

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts accepted frames so each one can be judged after it ends.
    always @(posedge clk) begin
        if (addr_hit === 1'b1) hits++;
        if (addr_general === 1'b1) gens++;
    end

    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt

    function automatic logic [10:0] gain_of(input logic [2:0] c);
        case (c)
            3'h0: return 11'h00a;
            3'h1: return 11'h01e;
            3'h2: return 11'h03c;
            3'h3: return 11'h07d;
            3'h4: return 11'h0fa;
            3'h5: return 11'h1f4;
            default: return 11'h3e8;
        endcase
    endfunction : gain_of

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // One load cycle: the gain code, select code and modes come from g, the rest is random.
    task automatic run(input logic [2:0] g);
        logic [6:0] own;
        logic [7:0] fr [3];
        logic [15:0] w;
        @(posedge clk);
        rst <= 1'b1;
        s = nxt(s);
        w = {s[15:14], g, s[10:6], g[1:0], s[3:0]};
        cfg <= w;
        s = nxt(s);
        acell <= {s[15:8], 1'b0, s[6:0]};
        addr_valid <= !g[1];
        own = g[1] ? 7'h5a : s[6:0];
        s = nxt(s);
        octl <= {s[15:3], g[0], g[2], s[0]};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 20 && cells_loaded !== 1'b1; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        check("fields", fields, w);
        check("gain", {gain_x10, byp, disc, rel, sgl},
            {gain_of(g), !g, g[1:0] == 2'h2 && !octl[0], octl[3], octl[0]});
        check("own", own_address, own);
        cfg <= i_host.keep_cal(w, ~w);
        acell <= ~acell;
        octl <= ~octl;
        repeat (4) @(posedge clk);
        check("hold", {fields, own_address, pwm_mode}, {w, own, g[2]});
        // Random pulse levels and bus pull requests; the pin follows one cycle later.
        repeat (12) begin
            @(posedge clk);
            s = nxt(s);
            pwm_level <= s[0];
            sda_drive_low <= s[1];
            @(posedge clk);
            @(negedge clk);
            check("pin", sda_wire, g[2] ? pwm_level : !sda_drive_low);
            check("drive", sda_pin_out, g[2] & g[0] & pwm_level);
        end
        @(posedge clk);
        sda_drive_low <= 1'b0;
        pwm_level <= 1'b1;
        // Let the released pin settle through the synchroniser before START.
        repeat (8) @(posedge clk);
        fr[0] = {own, 1'b1};
        fr[1] = 8'h00;
        fr[2] = {own ^ 7'h11, 1'b0};
        for (int f = 0; f < 3; f++) begin
            hits = 0;
            gens = 0;
            i_host.send_frame(fr[f]);
            repeat (8) @(posedge clk);
            check("hit", hits, !g[2] && (fr[f][7:1] == own || fr[f][7:1] == 7'h00));
            check("general", gens, !g[2] && fr[f][7:1] == 7'h00);
            if (!g[2]) check("rw", addr_read, fr[f][0]);
        end
    endtask : run

    // Main sequence: reset for ten cycles, then eight load cycles.
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        addr_valid = 1'b0;
        pwm_level = 1'b0;
        sda_drive_low = 1'b0;
        cfg = 16'h0000;
        acell = 16'h0000;
        octl = 16'h0000;
        s = 16'h0036;
        repeat (10) @(posedge clk);
        for (int i = 0; i < 8; i++) run(i[2:0]);
        wrap_up();
    end

    // A hang is cut short well beyond the expected few thousand cycles.
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule : testbench
